// *** emb_pkg.sv ***
// Purpose: shared constants and helpers of the external memory bus strobe block
// Assumes: one oscillator period per clk_sys_i cycle
// Notes: phase counts 0..11 within one machine cycle
// Behaviour
// RL1: Reset pin must stay high two machine cycles with clock running.
// RL2: Address latch strobe pulses so outside logic captures the low address byte.
// RL3: Address latch strobe runs at one sixth of the oscillator rate normally.
// RL4: One address latch pulse is dropped during each external data access.
// RL5: Auxiliary bit 0 set suppresses latch strobe except during external data moves.
// RL6: Program fetch strobe is the read strobe of external program memory.
// RL7: External code execution gives two program fetch strobes per machine cycle.
// RL8: Each external data access drops two consecutive program fetch strobes.
// RL9: Program fetch strobe stays inactive for internal code fetches.
// RL10: Fetch select held low forces all code fetches from external memory.
// RL11: Fetch select high fetches internally until the counter passes internal size.
// RL12: Fetch select level is latched at reset release, later changes ignored.
// RL13: Data write strobe on port three bit six, read strobe on bit seven.
// RL14: Port two carries high address for external fetches and 16-bit data accesses.
// RL15: One machine cycle lasts twelve oscillator periods.
package emb_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned OSC_PER_MCYCLE = 12; // [RL15]
	localparam int unsigned RST_HOLD_MCYCLES = 2;
	localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_MCYCLES * OSC_PER_MCYCLE; // [RL1]
	localparam logic [3:0] PHASE_LAST = 4'hb;

	// ==========================================================
	// Strobe slots within a machine cycle
	localparam logic [3:0] ALE_A_LO = 4'h0;
	localparam logic [3:0] ALE_A_HI = 4'h1;
	localparam logic [3:0] ALE_B_LO = 4'h6;
	localparam logic [3:0] ALE_B_HI = 4'h7;
	localparam logic [3:0] PROGRAM_FETCH_STROBE_A_LO = 4'h3;
	localparam logic [3:0] PROGRAM_FETCH_STROBE_A_HI = 4'h5;
	localparam logic [3:0] PROGRAM_FETCH_STROBE_B_LO = 4'h9;
	localparam logic [3:0] PROGRAM_FETCH_STROBE_B_HI = 4'hb;
	localparam logic [3:0] DSTB_LO = 4'h2;
	localparam logic [3:0] DSTB_HI = 4'h9;
	localparam logic [3:0] RDATA_PHASE = 4'h9;

	// ==========================================================
	// Internal program memory limits
	localparam logic [15:0] INT_LAST_8K = 16'h1fff;
	localparam logic [15:0] INT_LAST_16K = 16'h3fff;
	localparam logic [15:0] INT_LAST_32K = 16'h7fff;
	localparam logic [1:0] SIZE_8K = 2'h0;
	localparam logic [1:0] SIZE_16K = 2'h1;
	localparam logic [1:0] SIZE_32K = 2'h2;

	// ==========================================================
	// Reset values
	localparam logic EXT_SEL_RST = 1'b1;
	localparam logic [3:0] PHASE_RST = 4'h0;

	typedef enum logic [1:0]
	{
		EMB_IDLE = 2'b00,
		EMB_DATA = 2'b01
	} emb_state_type;

	function automatic logic emb_in_slot(input logic [3:0] ph, input logic [3:0] lo,
		input logic [3:0] hi);
		emb_in_slot = (ph >= lo) && (ph <= hi);
	endfunction : emb_in_slot

	function automatic logic [15:0] emb_int_last(input logic [1:0] sel);
		case (sel)
			SIZE_8K: emb_int_last = INT_LAST_8K;
			SIZE_16K: emb_int_last = INT_LAST_16K;
			default: emb_int_last = INT_LAST_32K;
		endcase
	endfunction : emb_int_last

endpackage : emb_pkg

// *** emb_timing_if.sv ***
// Purpose: carries machine cycle timing and qualified reset between modules
// Assumes: single clock domain
// Notes: none
`timescale 1ns/10ps
interface emb_timing_if;
	logic [3:0] phase;
	logic cycle_last;
	logic core_rst;
	logic ext_sel;

	modport gen
	(
		output phase,
		output cycle_last,
		input core_rst
	);
	modport qual
	(
		output core_rst,
		output ext_sel
	);
	modport use_side
	(
		input phase,
		input cycle_last,
		input core_rst,
		input ext_sel
	);
endinterface : emb_timing_if

// *** emb_reset_qual.sv ***
// Purpose: qualifies the reset pin and latches the fetch select level
// Assumes: pins are asynchronous to clk_sys_i
// Notes: both pins pass two flip-flops first
`timescale 1ns/10ps
module emb_reset_qual
	import emb_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Pins
	input wire logic reset_pin_i,
	input wire logic external_fetch_select_i,
	// Timing carrier
	emb_timing_if.qual tim
);

	// ==========================================================
	// Synchronisers
	logic rst_s1_q;
	logic rst_s2_q;
	logic sel_s1_q;
	logic sel_s2_q;
	logic [4:0] hold_q;
	logic [4:0] hold_d;
	logic core_rst_q;
	logic ext_sel_q;
	wire logic hold_done;
	wire logic release_now;

	localparam logic [4:0] HOLD_TOP = 5'(RST_HOLD_CYCLES - 1);

	// Short high glitches on the pin never reach the core
	assign hold_done = rst_s2_q && (hold_q == HOLD_TOP); // [RL1]
	assign release_now = core_rst_q && !rst_s2_q;
	assign hold_d = rst_s2_q ? (hold_done ? hold_q : hold_q + 5'h1) : 5'h0;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			// Pin counts as held until both stages have seen it low
			rst_s1_q <= 1'b1;
			rst_s2_q <= 1'b1;
			sel_s1_q <= EXT_SEL_RST;
			sel_s2_q <= EXT_SEL_RST;
		end
		else
		begin
			rst_s1_q <= reset_pin_i;
			rst_s2_q <= rst_s1_q;
			sel_s1_q <= external_fetch_select_i;
			sel_s2_q <= sel_s1_q;
		end
	end

	// ==========================================================
	// Qualified reset and fetch select latch
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			hold_q <= 5'h0;
			core_rst_q <= 1'b1;
			ext_sel_q <= EXT_SEL_RST;
		end
		else
		begin
			hold_q <= hold_d;
			if (hold_done)
				core_rst_q <= 1'b1; // [RL1]
			else if (release_now)
				core_rst_q <= 1'b0;
			if (release_now)
				ext_sel_q <= sel_s2_q; // [RL12]
		end
	end

	assign tim.core_rst = core_rst_q;
	// Live level in reset so the first cycle after release already uses it
	assign tim.ext_sel = core_rst_q ? sel_s2_q : ext_sel_q; // [RL12]

endmodule : emb_reset_qual

// *** emb_phase_gen.sv ***
// Purpose: counts oscillator periods inside each machine cycle
// Assumes: qualified reset realigns the cycle
// Notes: phase 11 is the last period of a cycle
`timescale 1ns/10ps
module emb_phase_gen
	import emb_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Timing carrier
	emb_timing_if.gen tim
);

	// ==========================================================
	// Phase counter
	logic [3:0] phase_q;
	wire logic wrap;

	assign wrap = (phase_q == PHASE_LAST);

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || tim.core_rst)
			phase_q <= PHASE_RST;
		else
			phase_q <= wrap ? PHASE_RST : phase_q + 4'h1; // [RL15]
	end

	assign tim.phase = phase_q;
	assign tim.cycle_last = wrap;

endmodule : emb_phase_gen

// *** emb_strobes.sv ***
// Purpose: external memory bus strobes, fetch select and high address
// Assumes: the core presents data requests and pc ahead of each machine cycle
// Notes: strobes named _n are active low pins
`timescale 1ns/10ps
module emb_strobes
	import emb_pkg::*;
#(
	parameter logic [1:0] MEM_SIZE = SIZE_32K
)
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Pins in
	input wire logic reset_pin_i,
	input wire logic external_fetch_select_i,
	input wire logic [7:0] port_zero_i,
	// Core side
	input wire logic [15:0] pc_i,
	input wire logic aux_ale_off_i,
	input wire logic external_data_move_i,
	input wire logic data_req_i,
	input wire logic data_write_i,
	input wire logic data_addr16_i,
	input wire logic [15:0] data_addr_i,
	output logic data_req_ready_o,
	output logic data_done_o,
	output logic [7:0] data_rdata_o,
	output logic fetch_external_o,
	output logic core_reset_o,
	output logic cycle_last_o,
	// Pins out
	output logic addr_latch_strobe_o,
	output logic program_fetch_strobe_n_o,
	output logic port_three_bit_six_o,
	output logic port_three_bit_seven_o,
	output logic [7:0] port_two_o,
	output logic port_two_oe_o
);

	// ==========================================================
	// Timing
	emb_timing_if tim ();

	emb_reset_qual u_reset_qual
	(
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.reset_pin_i(reset_pin_i),
		.external_fetch_select_i(external_fetch_select_i),
		.tim(tim.qual)
	);

	emb_phase_gen u_phase_gen
	(
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.tim(tim.gen)
	);

	// ==========================================================
	// Read data synchroniser
	logic [7:0] pz_s1_q;
	logic [7:0] pz_s2_q;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pz_s1_q <= 8'h00;
			pz_s2_q <= 8'h00;
		end
		else
		begin
			pz_s1_q <= port_zero_i;
			pz_s2_q <= pz_s1_q;
		end
	end

	// ==========================================================
	// Fetch source
	wire logic [15:0] int_last;
	wire logic pc_beyond;
	wire logic fetch_ext_d;
	logic fetch_ext_q;

	assign int_last = emb_int_last(MEM_SIZE);
	assign pc_beyond = (pc_i > int_last); // [RL11]
	// Latched low select sends every fetch outside, from address zero on
	assign fetch_ext_d = !tim.ext_sel || pc_beyond; // [RL10] [RL11]

	// ==========================================================
	// Data cycle sequencer
	emb_state_type state_q;
	emb_state_type state_d;
	logic wr_q;
	logic addr16_q;
	logic [7:0] addr_hi_q;
	logic done_q;
	logic [7:0] rdata_q;
	wire logic take_req;
	wire logic in_data;
	wire logic data_end;

	// Requests are only sampled at a cycle boundary so a data cycle is whole
	assign data_req_ready_o = tim.cycle_last && !tim.core_rst;
	assign take_req = data_req_ready_o && data_req_i;
	assign in_data = (state_q == EMB_DATA);
	assign data_end = in_data && tim.cycle_last;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			EMB_IDLE:
				if (take_req)
					state_d = EMB_DATA;
			EMB_DATA:
				if (tim.cycle_last && !take_req)
					state_d = EMB_IDLE;
			default:
				state_d = EMB_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || tim.core_rst)
			state_q <= EMB_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			wr_q <= 1'b0;
			addr16_q <= 1'b0;
			addr_hi_q <= 8'h00;
			fetch_ext_q <= 1'b0;
		end
		else
		begin
			if (take_req)
			begin
				wr_q <= data_write_i;
				addr16_q <= data_addr16_i;
				addr_hi_q <= data_addr_i[15:8];
			end
			// Reloaded in core reset, so fetching from zero starts on the right side
			if (tim.cycle_last || tim.core_rst)
				fetch_ext_q <= fetch_ext_d; // [RL10]
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || tim.core_rst)
		begin
			done_q <= 1'b0;
			rdata_q <= 8'h00;
		end
		else
		begin
			done_q <= data_end;
			if (in_data && !wr_q && (tim.phase == RDATA_PHASE))
				rdata_q <= pz_s2_q;
		end
	end

	// ==========================================================
	// Strobe decode
	wire logic ale_slot_a;
	wire logic ale_slot_b;
	wire logic ale_allowed;
	wire logic ale_d;
	wire logic program_fetch_strobe_slot;
	wire logic program_fetch_strobe_d;
	wire logic dstb_slot;
	wire logic wr_d;
	wire logic rd_d;
	wire logic p2_data;
	wire logic p2_fetch;
	wire logic [7:0] p2_val_d;
	wire logic p2_oe_d;

	assign ale_slot_a = emb_in_slot(tim.phase, ALE_A_LO, ALE_A_HI); // [RL3]
	assign ale_slot_b = emb_in_slot(tim.phase, ALE_B_LO, ALE_B_HI); // [RL3]
	// Inhibit trades the free running timing output for lower emissions
	assign ale_allowed = !aux_ale_off_i || external_data_move_i || in_data; // [RL5]
	// First slot of the data cycle carries no new address, so it is dropped
	assign ale_d = !tim.core_rst && ale_allowed
		&& (ale_slot_b || (ale_slot_a && !in_data)); // [RL2] [RL4]

	assign program_fetch_strobe_slot = emb_in_slot(tim.phase, PROGRAM_FETCH_STROBE_A_LO, PROGRAM_FETCH_STROBE_A_HI)
		|| emb_in_slot(tim.phase, PROGRAM_FETCH_STROBE_B_LO, PROGRAM_FETCH_STROBE_B_HI); // [RL7]
	assign program_fetch_strobe_d = !tim.core_rst && fetch_ext_q && program_fetch_strobe_slot && !in_data; // [RL6] [RL8] [RL9]

	assign dstb_slot = in_data && emb_in_slot(tim.phase, DSTB_LO, DSTB_HI);
	assign wr_d = dstb_slot && wr_q; // [RL13]
	assign rd_d = dstb_slot && !wr_q; // [RL13]

	assign p2_data = in_data && addr16_q; // [RL14]
	assign p2_fetch = !in_data && fetch_ext_q; // [RL14]
	assign p2_val_d = p2_data ? addr_hi_q : pc_i[15:8];
	assign p2_oe_d = !tim.core_rst && (p2_data || p2_fetch);

	// ==========================================================
	// Output registers
	logic ale_q;
	logic program_fetch_strobe_q;
	logic wr_q_o;
	logic rd_q_o;
	logic [7:0] p2_q;
	logic p2_oe_q;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			ale_q <= 1'b0;
			program_fetch_strobe_q <= 1'b0;
			wr_q_o <= 1'b0;
			rd_q_o <= 1'b0;
			p2_q <= 8'h00;
			p2_oe_q <= 1'b0;
		end
		else
		begin
			ale_q <= ale_d;
			program_fetch_strobe_q <= program_fetch_strobe_d;
			wr_q_o <= wr_d;
			rd_q_o <= rd_d;
			p2_q <= p2_val_d;
			p2_oe_q <= p2_oe_d;
		end
	end

	assign addr_latch_strobe_o = ale_q;
	assign program_fetch_strobe_n_o = !program_fetch_strobe_q;
	assign port_three_bit_six_o = !wr_q_o;
	assign port_three_bit_seven_o = !rd_q_o;
	assign port_two_o = p2_q;
	assign port_two_oe_o = p2_oe_q;
	assign data_done_o = done_q;
	assign data_rdata_o = rdata_q;
	assign fetch_external_o = fetch_ext_q;
	assign core_reset_o = tim.core_rst;
	assign cycle_last_o = tim.cycle_last;

endmodule : emb_strobes

// *** emb_strobes_asserts.sv ***
// Purpose: port-level checks of the strobe block
// Assumes: one clock, rst_i synchronous
// Notes: bound into every emb_strobes
`timescale 1ns/10ps
module emb_strobes_asserts
	import emb_pkg::*;
#(
	parameter logic [1:0] MEM_SIZE = SIZE_32K
)
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Core side
	input wire logic [15:0] pc_i,
	input wire logic aux_ale_off_i,
	input wire logic external_data_move_i,
	input wire logic data_req_i,
	input wire logic data_write_i,
	input wire logic data_addr16_i,
	input wire logic [15:0] data_addr_i,
	input wire logic data_req_ready_o,
	input wire logic fetch_external_o,
	input wire logic core_reset_o,
	input wire logic cycle_last_o,
	// Pins
	input wire logic addr_latch_strobe_o,
	input wire logic program_fetch_strobe_n_o,
	input wire logic port_three_bit_six_o,
	input wire logic [7:0] port_two_o,
	input wire logic port_two_oe_o
);
	// ====
	// Helpers
	localparam logic [15:0] LAST = (MEM_SIZE == SIZE_8K) ? INT_LAST_8K :
		(MEM_SIZE == SIZE_16K) ? INT_LAST_16K : INT_LAST_32K;
	logic take;
	logic [7:0] hi_q;
	assign take = data_req_i && data_req_ready_o;
	always_ff @(posedge clk_sys_i)
	begin
		if (take)
			hi_q <= data_addr_i[15:8];
	end
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// ====
	// Properties
	property p_ale_width;
		$rose(addr_latch_strobe_o) |=> addr_latch_strobe_o ##1 !addr_latch_strobe_o;
	endproperty
	a_ale_width: assert property (p_ale_width) else $error("latch pulse width");
	property p_ale_rate;
		cycle_last_o && !core_reset_o && !aux_ale_off_i
			##1 (!aux_ale_off_i && !core_reset_o)[*7] |=> addr_latch_strobe_o;
	endproperty
	a_ale_rate: assert property (p_ale_rate) else $error("latch pulse missing");
	property p_ale_drop;
		take |-> ##2 (!addr_latch_strobe_o)[*2];
	endproperty
	a_ale_drop: assert property (p_ale_drop) else $error("latch not dropped");
	// Three samples cover a pipelined auxiliary bit
	property p_ale_off;
		(aux_ale_off_i && !external_data_move_i)[*3] |-> !addr_latch_strobe_o;
	endproperty
	a_ale_off: assert property (p_ale_off) else $error("latch not suppressed");
	property p_fetch_two;
		cycle_last_o && !core_reset_o && !data_req_i ##1 fetch_external_o |->
			##4 (!program_fetch_strobe_n_o)[*3] ##1 program_fetch_strobe_n_o[*3]
			##1 (!program_fetch_strobe_n_o)[*3];
	endproperty
	a_fetch_two: assert property (p_fetch_two) else $error("fetch strobes wrong");
	property p_fetch_skip;
		take |-> ##5 program_fetch_strobe_n_o[*3] ##4 program_fetch_strobe_n_o[*3];
	endproperty
	a_fetch_skip: assert property (p_fetch_skip) else $error("fetch not skipped");
	property p_fetch_int;
		!program_fetch_strobe_n_o |-> $past(fetch_external_o);
	endproperty
	a_fetch_int: assert property (p_fetch_int) else $error("internal fetch strobed");
	property p_source;
		cycle_last_o && !core_reset_o && pc_i > LAST |=> fetch_external_o;
	endproperty
	a_source: assert property (p_source) else $error("fetch source wrong");
	property p_write;
		take && data_write_i |-> ##4 (!port_three_bit_six_o)[*8] ##1 port_three_bit_six_o;
	endproperty
	a_write: assert property (p_write) else $error("write strobe wrong");
	property p_high;
		take && data_addr16_i |-> ##2 (port_two_oe_o && port_two_o == hi_q)[*8];
	endproperty
	a_high: assert property (p_high) else $error("high address wrong");
	cover property (take && data_write_i);
	cover property (take && !data_write_i);
	cover property (aux_ale_off_i && external_data_move_i && addr_latch_strobe_o);
endmodule : emb_strobes_asserts

bind emb_strobes emb_strobes_asserts #(.MEM_SIZE(MEM_SIZE)) u_chk (.*);

// *** emb_ext_mem.sv ***
// Purpose: external memory seen through the strobes
// Assumes: data byte is a fixed function of the high address
// Notes: slow_i adds two wait clocks
`timescale 1ns/10ps
module emb_ext_mem
(
	// Clock
	input wire logic clk_sys_i,
	// Strobes and address
	input wire logic fetch_strobe_n_i,
	input wire logic read_strobe_n_i,
	input wire logic [7:0] addr_hi_i,
	input wire logic slow_i,
	// Data bus
	output logic [7:0] bus_o
);
	int wait_q = 0;
	initial bus_o = 8'h00;
	// Released bus toggles every clock, so it never holds a stale byte
	always @(posedge clk_sys_i)
	begin
		if ((read_strobe_n_i && fetch_strobe_n_i) || wait_q < (slow_i ? 2 : 0))
		begin
			bus_o <= ~bus_o;
			wait_q <= (read_strobe_n_i && fetch_strobe_n_i) ? 0 : wait_q + 1;
		end
		else
			bus_o <= addr_hi_i ^ 8'h5a;
	end
endmodule : emb_ext_mem

// *** tb_top.sv ***
// Purpose: self-checking bench of the strobe block
// Assumes: 250 MHz clock, inputs change on falling edges
// Notes: read results are matched through a queue
`timescale 1ns/10ps
module tb_top;
	import emb_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic pin = 1'b0;
	logic ext_sel = 1'b1;
	logic [15:0] pc = 16'h0000;
	logic aux = 1'b0;
	logic edm = 1'b0;
	logic req = 1'b0;
	logic wr = 1'b0;
	logic a16 = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic slow = 1'b0;
	logic [7:0] bus, rdata, p2;
	logic ready, done, fext, core_rst, ale, program_fetch_strobe_n, rd_n, cyc;
	logic [8:0] note;
	logic [8:0] notes[$];
	int errors = 0;
	int num_checks = 0;
	int seed = 77823;
	int na, np;
	always #2 clk_sys_i = ~clk_sys_i;
	emb_strobes #(.MEM_SIZE(SIZE_32K)) DUT
	(
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reset_pin_i(pin),
		.external_fetch_select_i(ext_sel), .port_zero_i(bus), .pc_i(pc),
		.aux_ale_off_i(aux), .external_data_move_i(edm), .data_req_i(req),
		.data_write_i(wr), .data_addr16_i(a16), .data_addr_i(addr),
		.data_req_ready_o(ready), .data_done_o(done), .data_rdata_o(rdata),
		.fetch_external_o(fext), .core_reset_o(core_rst), .cycle_last_o(cyc),
		.addr_latch_strobe_o(ale), .program_fetch_strobe_n_o(program_fetch_strobe_n),
		.port_three_bit_six_o(), .port_three_bit_seven_o(rd_n),
		.port_two_o(p2), .port_two_oe_o()
	);
	emb_ext_mem u_mem (.clk_sys_i(clk_sys_i), .fetch_strobe_n_i(program_fetch_strobe_n),
		.read_strobe_n_i(rd_n), .addr_hi_i(p2), .slow_i(slow), .bus_o(bus));
	// ====
	// Tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// Mode changes only in the last phase, so no latch pulse is cut short
	task automatic align();
		@(negedge clk_sys_i);
		while (cyc !== 1'b1)
			@(negedge clk_sys_i);
	endtask : align
	task automatic count(input int n);
		logic a0, p0;
		na = 0;
		np = 0;
		a0 = ale;
		p0 = program_fetch_strobe_n;
		repeat (n)
		begin
			@(negedge clk_sys_i);
			na += int'(ale && !a0);
			np += int'(!program_fetch_strobe_n && p0);
			a0 = ale;
			p0 = program_fetch_strobe_n;
		end
	endtask : count
	task automatic access(input logic w);
		int k;
		k = 0;
		@(negedge clk_sys_i);
		while (ready !== 1'b1 && k < 30)
		begin
			@(negedge clk_sys_i);
			k++;
		end
		wr = w;
		a16 = 1'($random(seed));
		addr = 16'($random(seed));
		slow = 1'($random(seed));
		req = 1'b1;
		notes.push_back({w, (a16 ? addr[15:8] : pc[15:8]) ^ 8'h5a});
		@(negedge clk_sys_i);
		req = 1'b0;
	endtask : access
	// ====
	// Result watcher
	always @(negedge clk_sys_i)
	begin
		if (done === 1'b1)
		begin
			check(16'(notes.size() > 0), 16'h1);
			note = notes.pop_front();
			if (note[8] === 1'b0)
				check(16'(rdata), 16'(note[7:0]));
		end
	end
	// ====
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (20) @(negedge clk_sys_i);
		check(16'(core_rst), 16'h0);
		count(24);
		check(16'(na), 16'h4);
		check(16'(np), 16'h0);
		align();
		aux = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		count(24);
		check(16'(na), 16'h0);
		align();
		edm = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		count(24);
		check(16'(na), 16'h4);
		align();
		aux = 1'b0;
		edm = 1'b0;
		pc = 16'h7fff;
		repeat (14) @(negedge clk_sys_i);
		check(16'(fext), 16'h0);
		pc = 16'h8000;
		repeat (14) @(negedge clk_sys_i);
		check(16'(fext), 16'h1);
		count(24);
		check(16'(np), 16'h4);
		pc = 16'h0000;
		pin = 1'b1;
		repeat (10) @(negedge clk_sys_i);
		pin = 1'b0;
		repeat (6) @(negedge clk_sys_i);
		check(16'(core_rst), 16'h0);
		pin = 1'b1;
		ext_sel = 1'b0;
		repeat (30) @(negedge clk_sys_i);
		check(16'(core_rst), 16'h1);
		pin = 1'b0;
		repeat (8) @(negedge clk_sys_i);
		check(16'(fext), 16'h1);
		ext_sel = 1'b1;
		repeat (14) @(negedge clk_sys_i);
		check(16'(fext), 16'h1);
		access(1'b1);
		access(1'b0);
		repeat (6)
			access(1'($random(seed)));
		repeat (20) @(negedge clk_sys_i);
		check(16'(notes.size()), 16'h0);
		wrap_up();
	end
	// Whole run is under 1000 clocks
	initial
	begin
		#20000;
		errors++;
		wrap_up();
	end
endmodule : tb_top
